// ### cipher_glue_map.svh
`ifndef CIPHER_GLUE_MAP_SVH
`define CIPHER_GLUE_MAP_SVH

// System clock rate of the processor bus
`define GLUE_SYS_CLK_HZ        50000000
// Highest system clock for the same-frequency mode
`define GLUE_SAME_MODE_MAX_HZ  4000000

// Clock mode select pin levels
`define GLUE_MODE_SAME_LEVEL   1'b1
`define GLUE_MODE_DIV2_LEVEL   1'b0

// Reset values of the registered outputs and state
`define GLUE_STROBE_IDLE       1'b0
`define GLUE_PHASE_RESET       1'b0
`define GLUE_DIVIDER_RESET     1'b0
`define GLUE_SYNC_RESET        1'b1
`define GLUE_COUNT_RESET       8'h00

// Transfer counter width
`define GLUE_COUNT_W           8

`endif

// ### cipher_glue_pkg.sv
package cipher_glue_pkg;

   // Kind of processor I/O cycle seen at the port
   typedef enum logic [2:0] {
      CYC_IDLE      = 3'b000,
      CYC_LATCH     = 3'b001,
      CYC_READ      = 3'b010,
      CYC_WRITE     = 3'b011,
      CYC_WRITE_EXT = 3'b100
   } bus_cycle_t;

   // Cipher clock mode
   typedef enum logic {
      MODE_DIV2 = 1'b0,
      MODE_SAME = 1'b1
   } clk_mode_t;

endpackage

// ### level_sync.sv
`timescale 1ns/1ps
`default_nettype none

`include "cipher_glue_map.svh"

module level_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Asynchronous level in, synchronous level out
   input  wire logic level_in,
   output logic      level_out
);

   logic stage1_q;
   logic stage2_q;

   // First stage feeds only the second
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage1_q <= `GLUE_SYNC_RESET;
         stage2_q <= `GLUE_SYNC_RESET;
      end else begin
         stage1_q <= level_in;
         stage2_q <= stage1_q;
      end
   end

   assign level_out = stage2_q;

endmodule // level_sync

`default_nettype wire

// ### cipher_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none

`include "cipher_glue_map.svh"

module cipher_clock_gen
   import cipher_glue_pkg::*;
(
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      reset,
   // Control
   input  wire cipher_glue_pkg::clk_mode_t mode,
   input  wire logic                      phase_hold,
   // Clock to the cipher chip
   output logic                           cipher_clk
);

   import cipher_glue_pkg::*;

   logic div_q;
   logic div_d;

   // (RQ4) Divide by two
   // (RQ5) Half-cycle delay when out of phase
   always_comb begin
      div_d = ~div_q & ~phase_hold & (mode == MODE_DIV2);
   end

   always_ff @(posedge clk or posedge reset) begin
      // (RQ19) Divider to known state
      if (reset) begin
         div_q <= `GLUE_DIVIDER_RESET;
      end else begin
         div_q <= div_d;
      end
   end

   // (RQ3) Inverted system clock, same rate
   // (RQ13) Phase hold forces clock high
   // Gated clock path: mode must stay static while running
   assign cipher_clk = (mode == MODE_SAME) ? ~clk : ~div_q;

endmodule // cipher_clock_gen

`default_nettype wire

// ### cipher_port_glue.sv
// Notes on behaviour
// (RQ1) Even-address write latches register address; odd-address accesses move data.
// (RQ2) Register address stays latched until next address strobe; no new latch.
// (RQ3) Same-frequency mode: cipher clock is inverted system clock, no waits.
// (RQ4) Divide-by-two mode: cipher clock is system clock halved.
// (RQ5) Divided clock delayed half a cycle to line up with data strobe.
// (RQ6) Divide-by-two mode adds one wait state to each data write.
// (RQ7) Mode pin high selects same frequency, low selects divide-by-two.
// (RQ8) Data strobe rising edge meets a falling cipher clock edge.
// (RQ9) Chip select low only with request, select and address bit low.
// (RQ10) Address strobe low one clock in wait state, released before select.
// (RQ11) Read: select and address strobe idle; data strobe low wait and third.
// (RQ12) Reads never request extra wait states.
// (RQ13) Phase flag set in first wait of each divided data cycle, read or write; forces cipher clock high.
// (RQ14) Write with address bit high moves one byte; select and strobe idle.
// (RQ15) Same-frequency write: data strobe low for wait state only.
// (RQ16) Divide-by-two write: data strobe low over both wait states.
// (RQ17) Divide-by-two mode needs the faster cipher chip variant.
// (RQ18) Wait output driven low only in first divided write wait.
// (RQ19) Reset clears divider and phase, strobes idle, wait released.
`timescale 1ns/1ps
`default_nettype none

`include "cipher_glue_map.svh"

module cipher_port_glue
   import cipher_glue_pkg::*;
(
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       reset,
   // Processor I/O bus, same clock as clk
   input  wire logic                       io_request_n,
   input  wire logic                       dev_select_n,
   input  wire logic                       addr0,
   input  wire logic                       write_n,
   // Static clock mode pin
   input  wire logic                       clock_mode_pin,
   // Cipher chip master port
   output logic                            port_chip_select_n,
   output logic                            port_address_strobe_n,
   output logic                            port_data_strobe_n,
   output logic                            cipher_clk,
   // Open-drain wait request to the processor
   output logic                            wait_out,
   output logic                            wait_oe_n,
   // Observation
   output cipher_glue_pkg::bus_cycle_t     cycle_kind,
   output logic                            phase_flag,
   output logic [`GLUE_COUNT_W-1:0]        data_count
);

   import cipher_glue_pkg::*;

   // Decoded access classes
   function automatic logic access_hit(input logic req_n,
                                       input logic sel_n);
      access_hit = ~req_n & ~sel_n;
   endfunction

   function automatic logic is_latch(input logic hit,
                                     input logic a0,
                                     input logic wr_n);
      is_latch = hit & ~a0 & ~wr_n;
   endfunction

   function automatic logic is_data(input logic hit,
                                    input logic a0);
      is_data = hit & a0;
   endfunction

   // Mode pin is static but asynchronous to clk
   logic      mode_level;
   clk_mode_t mode;

   level_sync u_mode_sync (
      .clk       (clk),
      .reset     (reset),
      .level_in  (clock_mode_pin),
      .level_out (mode_level)
   );

   // (RQ7) High level selects same-frequency mode
   always_comb begin
      if (mode_level == `GLUE_MODE_SAME_LEVEL) begin
         mode = MODE_SAME;
      end else begin
         mode = MODE_DIV2;
      end
   end

   // Bus decode
   logic hit;
   logic wr;
   logic latch_acc;
   logic data_acc;
   logic read_acc;
   logic write_acc;
   logic div2;

   assign hit       = access_hit(io_request_n, dev_select_n);
   assign wr        = ~write_n;
   assign latch_acc = is_latch(hit, addr0, write_n);
   assign data_acc  = is_data(hit, addr0);
   assign read_acc  = data_acc & ~wr;
   assign write_acc = data_acc & wr;
   assign div2      = (mode == MODE_DIV2);

   // (RQ9) Chip select from request, select and even address
   // Combinational so it frames the whole address cycle
   assign port_chip_select_n = ~(hit & ~addr0);

   // Address strobe
   logic as_q;
   logic as_d;

   // (RQ10) One clock pulse, self-clearing before select ends
   // (RQ1) Even-address write is the latch cycle
   always_comb begin
      as_d = latch_acc & ~as_q;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         as_q <= `GLUE_STROBE_IDLE;
      end else begin
         as_q <= as_d;
      end
   end

   assign port_address_strobe_n = ~as_q;

   // Phase flag and data strobe
   logic ds_q;
   logic ds_d;
   logic ph_q;
   logic ph_d;

   // (RQ13) Set in the first wait of a divided data cycle
   always_comb begin
      ph_d = data_acc & ~ds_q & ~ph_q & div2;
   end

   // (RQ8) Strobe timed against the falling cipher clock
   always_comb begin
      ds_d = 1'b0;
      if (read_acc) begin
         // (RQ11) Read strobe over wait and third state
         ds_d = 1'b1;
      end else if (write_acc && !div2) begin
         // (RQ15) One state, captured at third state
         ds_d = ~ds_q;
      end else if (write_acc && div2) begin
         // (RQ16) Held across both wait states
         ds_d = (~ds_q & ~ph_q) | (ds_q & ph_q);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      // (RQ19) Strobe idle
      if (reset) begin
         ds_q <= `GLUE_STROBE_IDLE;
      end else begin
         ds_q <= ds_d;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      // (RQ19) Phase clear
      if (reset) begin
         ph_q <= `GLUE_PHASE_RESET;
      end else begin
         ph_q <= ph_d;
      end
   end

   // (RQ14) One byte per write, select and address strobe stay idle
   assign port_data_strobe_n = ~ds_q;
   assign phase_flag         = ph_q;

   // Cipher clock
   // (RQ5) Phase flag realigns the divider
   cipher_clock_gen u_clk_gen (
      .clk        (clk),
      .reset      (reset),
      .mode       (mode),
      .phase_hold (ph_q),
      .cipher_clk (cipher_clk)
   );

   // Wait request
   // (RQ6) One extra wait for divided writes
   // (RQ12) Reads never pull wait
   // (RQ18) Driven low only in first write wait
   assign wait_out  = 1'b0;
   assign wait_oe_n = ~(ph_q & wr & write_acc);

   // Cycle tracking
   bus_cycle_t cyc_q;
   bus_cycle_t cyc_d;

   always_comb begin
      cyc_d = CYC_IDLE;
      if (latch_acc) begin
         cyc_d = CYC_LATCH;
      end else if (read_acc) begin
         cyc_d = CYC_READ;
      end else if (write_acc && div2) begin
         cyc_d = CYC_WRITE_EXT;
      end else if (write_acc) begin
         cyc_d = CYC_WRITE;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cyc_q <= CYC_IDLE;
      end else begin
         cyc_q <= cyc_d;
      end
   end

   assign cycle_kind = cyc_q;

   // Data transfers since the last address latch
   logic [`GLUE_COUNT_W-1:0] cnt_q;
   logic [`GLUE_COUNT_W-1:0] cnt_d;
   logic                     data_start;

   // Counts each cycle once, on its first active clock
   always_comb begin
      case (cyc_q)
         CYC_READ, CYC_WRITE, CYC_WRITE_EXT: data_start = 1'b0;
         default:                            data_start = 1'b1;
      endcase
   end

   // (RQ2) Address held, data cycles reuse it
   always_comb begin
      cnt_d = cnt_q;
      if (as_d) begin
         cnt_d = `GLUE_COUNT_RESET;
      end else if (data_acc && data_start && cnt_q != {`GLUE_COUNT_W{1'b1}}) begin
         cnt_d = cnt_q + `GLUE_COUNT_W'(1);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_q <= `GLUE_COUNT_RESET;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign data_count = cnt_q;

endmodule // cipher_port_glue

`default_nettype wire

// ### cipher_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module cipher_port_model (
   // Reset
   input  wire logic  reset,
   // Master port pins
   input  wire logic  port_chip_select_n,
   input  wire logic  port_address_strobe_n,
   input  wire logic  port_data_strobe_n,
   // Observed activity
   output logic [7:0] latch_count,
   output logic [7:0] byte_count
);
   always @(negedge port_address_strobe_n or posedge reset) begin
      if (reset) latch_count <= 8'h00;
      else if (!port_chip_select_n) latch_count <= latch_count + 8'h01;
   end
   always @(posedge port_data_strobe_n or posedge reset) begin
      if (reset) byte_count <= 8'h00;
      else byte_count <= byte_count + 8'h01;
   end
   // Faster variant assumed, so no access time limit here
endmodule // cipher_port_model
`default_nettype wire

// ### cipher_port_glue_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module glue_checker (
   // Clock, reset and bus
   input wire logic clk,
   input wire logic reset,
   input wire logic io_request_n,
   input wire logic dev_select_n,
   input wire logic addr0,
   input wire logic write_n,
   input wire logic clock_mode_pin,
   // Port side
   input wire logic port_chip_select_n,
   input wire logic port_address_strobe_n,
   input wire logic port_data_strobe_n,
   input wire logic cipher_clk,
   input wire logic wait_out,
   input wire logic wait_oe_n,
   input wire logic phase_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   chk_select_decode: assert property (
      port_chip_select_n == (io_request_n || dev_select_n || addr0)) else $error("select");
   chk_astrobe_pulse: assert property (
      $fell(port_address_strobe_n) |=> port_address_strobe_n) else $error("as width");
   chk_astrobe_hold: assert property (
      !port_address_strobe_n |-> !port_chip_select_n) else $error("as hold");
   chk_data_idle: assert property (
      addr0 |-> port_chip_select_n && port_address_strobe_n) else $error("data idle");
   chk_read_strobe: assert property (
      $rose(!io_request_n && !dev_select_n && addr0) |=> !port_data_strobe_n)
      else $error("ds late");
   chk_read_nowait: assert property (
      addr0 && write_n |-> wait_oe_n) else $error("read wait");
   chk_wait_once: assert property (
      !wait_oe_n |-> !wait_out && phase_flag && !write_n ##1 wait_oe_n) else $error("wait");
   chk_phase_pulse: assert property (
      phase_flag |-> !port_data_strobe_n ##1 !phase_flag) else $error("phase");
   chk_same_write: assert property (
      $fell(port_data_strobe_n) && !write_n && wait_oe_n |=> port_data_strobe_n)
      else $error("same write");
   chk_div2_write: assert property (
      $fell(port_data_strobe_n) && !wait_oe_n |=> !port_data_strobe_n) else $error("div2 wr");
   chk_same_nowait: assert property (
      clock_mode_pin && $past(clock_mode_pin, 3) |-> wait_oe_n) else $error("same wait");
   chk_strobe_clock: assert property (
      $rose(port_data_strobe_n) && !clock_mode_pin && !$past(clock_mode_pin, 3)
      |-> $fell(cipher_clk)) else $error("ds clock");
endmodule // glue_checker
bind cipher_port_glue glue_checker i_checker (.clk(clk), .reset(reset),
   .io_request_n(io_request_n), .dev_select_n(dev_select_n), .addr0(addr0),
   .write_n(write_n), .clock_mode_pin(clock_mode_pin), .port_chip_select_n(port_chip_select_n),
   .port_address_strobe_n(port_address_strobe_n), .port_data_strobe_n(port_data_strobe_n),
   .cipher_clk(cipher_clk), .wait_out(wait_out), .wait_oe_n(wait_oe_n), .phase_flag(phase_flag));
`default_nettype wire

// ### io_bus_to_cipher_port_glue_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module io_bus_to_cipher_port_glue_tb_top;
   import cipher_glue_pkg::*;
   logic       clk, reset, io_request_n, dev_select_n, addr0, write_n, clock_mode_pin;
   logic       cs_n, as_n, ds_n, cclk, wait_out, wait_oe_n, phase_flag;
   bus_cycle_t cycle_kind;
   bus_cycle_t k0;
   logic [7:0] data_count, latch_count, byte_count, n_cs, n_as, n_ds, n_wt, n_ph;
   logic [7:0] n_rise = 8'h00;
   int         errors = 0;
   int         total_checks = 0;
   // Open-drain wait line with pull-up
   wire        wait_line_n = wait_oe_n ? 1'b1 : wait_out;
   cipher_port_glue i_dut (.clk(clk), .reset(reset), .io_request_n(io_request_n),
      .dev_select_n(dev_select_n), .addr0(addr0), .write_n(write_n),
      .clock_mode_pin(clock_mode_pin), .port_chip_select_n(cs_n), .port_address_strobe_n(as_n),
      .port_data_strobe_n(ds_n), .cipher_clk(cclk), .wait_out(wait_out),
      .wait_oe_n(wait_oe_n), .cycle_kind(cycle_kind), .phase_flag(phase_flag),
      .data_count(data_count));
   cipher_port_model i_model (.reset(reset), .port_chip_select_n(cs_n),
      .port_address_strobe_n(as_n), .port_data_strobe_n(ds_n),
      .latch_count(latch_count), .byte_count(byte_count));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge cclk) n_rise <= n_rise + 8'h01;
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Two bus edges per access, one more when wait is pulled; counts active samples
   task automatic access(input logic a0, input logic wr_n, input logic sel_n);
      int hold;
      hold = 1;
      n_cs = 8'h00;
      n_as = 8'h00;
      n_ds = 8'h00;
      n_wt = 8'h00;
      n_ph = 8'h00;
      @(negedge clk);
      io_request_n = 1'b0;
      dev_select_n = sel_n;
      addr0 = a0;
      write_n = wr_n;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         n_cs += {7'h00, ~cs_n};
         n_as += {7'h00, ~as_n};
         n_ds += {7'h00, ~ds_n};
         n_wt += {7'h00, ~wait_line_n};
         n_ph += {7'h00, phase_flag};
         if (i == 0) begin
            k0 = cycle_kind;
            // Processor stretches the cycle by one state while wait is low
            if (!wait_line_n) begin
               hold = 2;
            end
         end
         if (i == hold) begin
            io_request_n = 1'b1;
            dev_select_n = 1'b1;
            addr0 = 1'b1;
            write_n = 1'b1;
         end
      end
   endtask
   task automatic t_reset;
      repeat (10) @(negedge clk);
      check("reset idle", {ds_n, as_n, wait_oe_n, phase_flag, 1'b0, cycle_kind}, 8'he0);
      check("reset count", data_count, 8'h00);
   endtask
   task automatic t_same;
      access(1'b0, 1'b0, 1'b0);
      check("latch", {n_cs[3:0], n_as[1:0], n_ds[1:0]}, 8'h24);
      check("latch kind", {5'h00, k0}, {5'h00, CYC_LATCH});
      repeat (3) begin
         access(1'b1, 1'b0, 1'b0);
         check("same write", {n_cs[1:0], n_ds[1:0], n_wt[1:0], n_ph[1:0]}, 8'h10);
         check("write kind", {5'h00, k0}, {5'h00, CYC_WRITE});
      end
      repeat (2) begin
         access(1'b1, 1'b1, 1'b0);
         check("same read", {n_cs[3:0], n_ds[1:0], n_wt[1:0]}, 8'h08);
         check("read kind", {5'h00, k0}, {5'h00, CYC_READ});
      end
      check("held register", {latch_count[3:0], byte_count[3:0]}, 8'h15);
      check("data count", data_count, 8'h05);
      @(posedge clk);
      #5 check("inverted clock", {7'h00, cclk}, 8'h00);
      @(negedge clk);
      #5 check("inverted clock", {7'h00, cclk}, 8'h01);
   endtask
   task automatic t_refused;
      access(1'b0, 1'b1, 1'b0);
      check("even read", {n_cs[3:0], n_as[1:0], n_ds[1:0]}, 8'h20);
      check("even read kind", {5'h00, k0}, {5'h00, CYC_IDLE});
      access(1'b0, 1'b0, 1'b1);
      check("no select", {n_cs[3:0], n_as[3:0]}, 8'h00);
   endtask
   task automatic t_div2;
      logic [7:0] r0;
      clock_mode_pin = 1'b0;
      repeat (4) @(negedge clk);
      r0 = n_rise;
      repeat (20) @(negedge clk);
      check("halved clock", n_rise - r0, 8'h0a);
      access(1'b0, 1'b0, 1'b0);
      access(1'b1, 1'b0, 1'b0);
      check("div2 write", {n_ds[1:0], n_wt[1:0], n_ph[1:0], n_cs[1:0]}, 8'h94);
      check("div2 write kind", {5'h00, k0}, {5'h00, CYC_WRITE_EXT});
      access(1'b1, 1'b1, 1'b0);
      check("div2 read", {n_ds[1:0], n_wt[1:0], n_ph[1:0], n_as[1:0]}, 8'h84);
      check("div2 read kind", {5'h00, k0}, {5'h00, CYC_READ});
      check("div2 count", data_count, 8'h02);
      check("div2 model", {latch_count[3:0], byte_count[3:0]}, 8'h27);
      clock_mode_pin = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   initial begin
      reset = 1'b1;
      io_request_n = 1'b1;
      dev_select_n = 1'b1;
      addr0 = 1'b1;
      write_n = 1'b1;
      clock_mode_pin = 1'b1;
      t_reset();
      reset = 1'b0;
      repeat (3) @(negedge clk);
      t_same();
      t_refused();
      t_div2();
      complete_run();
   end
   // Hang guard, far beyond the roughly one hundred cycles the tests take
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      complete_run();
   end
endmodule // io_bus_to_cipher_port_glue_tb_top
`default_nettype wire
